// file: hdl/apss_defs.svh
// timing and encoding constants for the amplifier power stage sequencer
// assumes a single clk_i domain; hold and propagation counts are derived from the clock period in ns
`ifndef APSS_DEFS_SVH
`define APSS_DEFS_SVH
`define APSS_CLK_PERIOD_NS   10
`define APSS_HOLD_TIME_MS    650
`define APSS_PROP_DELAY_US   200
`define APSS_HOLD_CYCLES     ((`APSS_HOLD_TIME_MS * 1000000) / `APSS_CLK_PERIOD_NS)
`define APSS_PROP_CYCLES     ((`APSS_PROP_DELAY_US * 1000) / `APSS_CLK_PERIOD_NS)
`define APSS_RAMP_CYCLES     1024
`define APSS_CNT_W           32
`define APSS_RAMP_W          8
`endif

// file: hdl/apss_pkg.sv
// types shared by the amplifier power stage sequencer
// assumes apss_defs.svh is on the include path
`include "apss_defs.svh"
package apss_pkg;
   typedef enum logic [2:0] {
      APSS_ST_STANDBY = 3'b000,
      APSS_ST_HOLD    = 3'b001,
      APSS_ST_MUTED   = 3'b010,
      APSS_ST_RAMP    = 3'b011,
      APSS_ST_RUN     = 3'b100,
      APSS_ST_FAULT   = 3'b101
   } apss_state_t;

   typedef struct packed {
      logic overcurrent;
      logic overtemp;
      logic power_rail_ok;
      logic logic_rail_ok;
      logic clock_ok;
   } apss_mon_t;

   typedef struct packed {
      logic temp_warn_hi;
      logic temp_below_rel;
   } apss_temp_t;
endpackage

// file: hdl/apss_sequencer.sv
// power stage sequencer of a two-channel switching amplifier
// assumes all inputs synchronous to clk_i; open-drain flags given as out/enable pairs
`timescale 1ns/1ps
`include "apss_defs.svh"
// Summary of operation
// - pull thermal warning low at warning level
// - release warning only near 120 degrees
// - mute low stops all bridge switching
// - any fault event outside standby forces shutdown, asserts fault
// - fault latched; cleared by mute low, restarts on mute high
// - standby low stops modulator, outputs high-Z
// - standby high runs modulator, stage still high-Z
// - mute high enables stage via soft ramp
// - mute low disables the power stage
// - fixed hold after standby release, no switching
// - hold overrides early mute release
// - switch after hold plus 200us and unmuted
// - supply undervoltage blocks power stage turn-on
module apss_sequencer #(
   parameter int unsigned HOLD_CYCLES = `APSS_HOLD_CYCLES,
   parameter int unsigned PROP_CYCLES = `APSS_PROP_CYCLES,
   parameter int unsigned RAMP_CYCLES = `APSS_RAMP_CYCLES
) (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              clk_en_i,
   input  wire logic              standby_n_i,
   input  wire logic              mute_n_i,
   input  wire apss_pkg::apss_mon_t  mon_i,
   input  wire apss_pkg::apss_temp_t temp_i,
   output logic                   modulator_run_o,
   output logic                   bridge_enable_o,
   output logic [`APSS_RAMP_W-1:0] ramp_level_o,
   output logic                   thermal_warning_n_o,
   output logic                   thermal_warning_n_oe_n_o,
   output logic                   fault_n_o,
   output logic                   fault_n_oe_n_o
);
   import apss_pkg::*;

   // hold and propagation delay run as one count in the hold state
   localparam logic [`APSS_CNT_W-1:0] HOLD_END = `APSS_CNT_W'(HOLD_CYCLES + PROP_CYCLES - 1);
   localparam logic [`APSS_CNT_W-1:0] RAMP_END = `APSS_CNT_W'(RAMP_CYCLES - 1);

   // refuse counts that the counter or the ramp scaling cannot serve
   if (HOLD_CYCLES + PROP_CYCLES < 1 ||
       64'(HOLD_CYCLES) + 64'(PROP_CYCLES) > (64'h1 << `APSS_CNT_W)) begin : g_bad_hold
      $error("apss_sequencer: hold count out of range");
   end
   if (RAMP_CYCLES < 2) begin : g_bad_ramp
      $error("apss_sequencer: ramp needs at least two cycles");
   end
   if (RAMP_CYCLES > (32'h1 << (`APSS_CNT_W - `APSS_RAMP_W))) begin : g_big_ramp
      $error("apss_sequencer: ramp too long for level scaling");
   end

   apss_state_t             state_q, state_d;
   logic [`APSS_CNT_W-1:0]  cnt_q;
   logic                    standby_n_q;
   logic                    fault_q;
   logic                    warn_q;
   logic                    fault_event;

   // any monitor bit in its bad sense is a fault event
   function automatic logic any_fault(input apss_mon_t m);
      any_fault = m.overcurrent | m.overtemp | ~m.power_rail_ok | ~m.logic_rail_ok
                  | ~m.clock_ok;
   endfunction

   // both supply monitors must report good before turn-on
   function automatic logic rails_ok(input apss_mon_t m);
      rails_ok = m.power_rail_ok & m.logic_rail_ok;
   endfunction

   // bridge switches only in the ramp and run states
   function automatic logic stage_on(input apss_state_t s);
      stage_on = (s == APSS_ST_RAMP) || (s == APSS_ST_RUN);
   endfunction

   assign fault_event = any_fault(mon_i);

   // standby history for the rising-edge detect
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         standby_n_q <= 1'b0;
      end else if (clk_en_i) begin
         standby_n_q <= standby_n_i;
      end
   end

   // fault latch; a new event wins over the mute-low clear
   // events in standby are ignored so a rail dropping at power-down stays silent
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fault_q <= 1'b0;
      end else if (clk_en_i) begin
         if (fault_event && standby_n_i) begin
            fault_q <= 1'b1;
         end else if (!mute_n_i) begin
            fault_q <= 1'b0;
         end
      end
   end

   // thermal warning with hysteresis
   // set wins when both monitor bits are up
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         warn_q <= 1'b0;
      end else if (clk_en_i) begin
         if (temp_i.temp_warn_hi) begin
            warn_q <= 1'b1;
         end else if (temp_i.temp_below_rel) begin
            warn_q <= 1'b0;
         end
      end
   end

   // next-state logic; standby beats fault, fault beats mute
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         APSS_ST_STANDBY: begin
            if (standby_n_i && !standby_n_q)
               state_d = APSS_ST_HOLD;
         end
         APSS_ST_HOLD: begin
            // mute input ignored until hold plus propagation delay expires
            if (cnt_q == HOLD_END)
               state_d = APSS_ST_MUTED;
         end
         APSS_ST_MUTED: begin
            // level-sensitive; a fault cleared by mute low waits here for mute high
            if (mute_n_i && !fault_q && rails_ok(mon_i))
               state_d = APSS_ST_RAMP;
         end
         APSS_ST_RAMP: begin
            if (cnt_q == RAMP_END)
               state_d = APSS_ST_RUN;
         end
         APSS_ST_RUN: begin
            // stays until an override below moves it
            state_d = APSS_ST_RUN;
         end
         APSS_ST_FAULT: begin
            if (!mute_n_i)
               state_d = APSS_ST_MUTED;
         end
         default: state_d = APSS_ST_STANDBY;
      endcase
      // overrides in priority order
      if (stage_on(state_q)) begin
         if (!mute_n_i || !rails_ok(mon_i))
            state_d = APSS_ST_MUTED;
      end
      if (fault_event && state_q != APSS_ST_STANDBY)
         state_d = APSS_ST_FAULT;
      if (!standby_n_i)
         state_d = APSS_ST_STANDBY;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= APSS_ST_STANDBY;
      end else if (clk_en_i) begin
         state_q <= state_d;
      end
   end

   // shared counter for hold and ramp phases
   // cleared on every state change so each phase starts from zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q <= '0;
      end else if (clk_en_i) begin
         if (state_d != state_q) begin
            cnt_q <= '0;
         end else if (state_q == APSS_ST_HOLD || state_q == APSS_ST_RAMP) begin
            cnt_q <= cnt_q + `APSS_CNT_W'(1);
         end
      end
   end

   // registered outputs
   // built from the next state so they change together with the state register
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         modulator_run_o <= 1'b0;
         bridge_enable_o <= 1'b0;
         ramp_level_o    <= '0;
      end else if (clk_en_i) begin
         modulator_run_o <= (state_d != APSS_ST_STANDBY);
         bridge_enable_o <= stage_on(state_d);
         if (state_d == APSS_ST_RUN) begin
            ramp_level_o <= '1;
         end else if (state_d == APSS_ST_RAMP) begin
            // level scales the ramp count to full range, saturating at the end
            ramp_level_o <= cnt_q[`APSS_CNT_W-1:0] >= RAMP_END ? '1 :
                            `APSS_RAMP_W'((cnt_q * (2 ** `APSS_RAMP_W)) / RAMP_CYCLES);
         end else begin
            ramp_level_o <= '0;
         end
      end
   end

   // open-drain flags: enable low while pulling the pin low
   // data is tied low; only the enable moves, so the pin never drives high
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         thermal_warning_n_o      <= 1'b0;
         thermal_warning_n_oe_n_o <= 1'b1;
         fault_n_o                <= 1'b0;
         fault_n_oe_n_o           <= 1'b1;
      end else if (clk_en_i) begin
         thermal_warning_n_o      <= 1'b0;
         thermal_warning_n_oe_n_o <= ~warn_q;
         fault_n_o                <= 1'b0;
         fault_n_oe_n_o           <= ~fault_q;
      end
   end
endmodule // apss_sequencer

// file: test/apss_sequencer_assertions.sv
// port-level checks for the amplifier power stage sequencer
// assumes bind onto apss_sequencer, single clk_i domain
`timescale 1ns/1ps
`include "apss_defs.svh"
module apss_chk #(
   parameter int unsigned HOLD_CYCLES = 50,
   parameter int unsigned PROP_CYCLES = 5
) (
   input wire logic                    clk_i,
   input wire logic                    reset_i,
   input wire logic                    clk_en_i,
   input wire logic                    standby_n_i,
   input wire logic                    mute_n_i,
   input wire apss_pkg::apss_mon_t     mon_i,
   input wire apss_pkg::apss_temp_t    temp_i,
   input wire logic                    modulator_run_o,
   input wire logic                    bridge_enable_o,
   input wire logic [`APSS_RAMP_W-1:0] ramp_level_o,
   input wire logic                    thermal_warning_n_oe_n_o,
   input wire logic                    fault_n_oe_n_o
);
   import apss_pkg::*;
   int unsigned run_q;
   // cycles the modulator has been running, saturating
   always_ff @(posedge clk_i) begin
      if (reset_i || !modulator_run_o) run_q <= 0;
      else if (clk_en_i && run_q < HOLD_CYCLES + PROP_CYCLES) run_q <= run_q + 1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_standby_off: assert property (clk_en_i && !standby_n_i |=>
      !modulator_run_o && !bridge_enable_o) else $error("stage on in standby");
   chk_mute_off: assert property (clk_en_i && !mute_n_i |=> !bridge_enable_o)
      else $error("bridge on while muted");
   chk_fault_set: assert property ((clk_en_i && standby_n_i && modulator_run_o &&
      (mon_i.overcurrent || mon_i.overtemp || !mon_i.power_rail_ok || !mon_i.logic_rail_ok
      || !mon_i.clock_ok)) ##1 clk_en_i |=> !fault_n_oe_n_o && !bridge_enable_o)
      else $error("fault not flagged");
   chk_fault_hold: assert property (!fault_n_oe_n_o && mute_n_i && $past(mute_n_i) &&
      standby_n_i && $past(standby_n_i) |=> !fault_n_oe_n_o) else $error("fault flag lost");
   chk_warn_set: assert property (clk_en_i && temp_i.temp_warn_hi ##1 clk_en_i |=>
      !thermal_warning_n_oe_n_o) else $error("warning not flagged");
   chk_warn_hyst: assert property (!thermal_warning_n_oe_n_o &&
      !$past(temp_i.temp_below_rel) |=> !thermal_warning_n_oe_n_o) else $error("early release");
   chk_hold_block: assert property (bridge_enable_o |->
      run_q >= HOLD_CYCLES + PROP_CYCLES - 2) else $error("switching inside hold");
   chk_unmute_soft: assert property ($rose(bridge_enable_o) |-> $past(mute_n_i) &&
      ramp_level_o != 8'hFF) else $error("hard or muted turn-on");
endmodule // apss_chk
bind apss_sequencer apss_chk #(.HOLD_CYCLES(HOLD_CYCLES), .PROP_CYCLES(PROP_CYCLES)) u_chk (
   .clk_i, .reset_i, .clk_en_i, .standby_n_i, .mute_n_i, .mon_i, .temp_i, .modulator_run_o,
   .bridge_enable_o, .ramp_level_o, .thermal_warning_n_oe_n_o, .fault_n_oe_n_o);

// file: test/apss_ctrl_model.sv
// system controller model driving standby and mute
// assumes the bench requests power-up with up_i and forced mute with mute_req_i
`timescale 1ns/1ps
module apss_ctrl_model #(
   parameter int WAIT = 80
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic up_i,
   input  wire logic early_i,
   input  wire logic mute_req_i,
   output logic      standby_n_o,
   output logic      mute_n_o
);
   int   cnt_q;
   logic sb_q;
   logic um_q;
   logic um_dly;
   always_ff @(posedge clk_i) begin
      if (reset_i || !up_i) cnt_q <= 0;
      else if (cnt_q < WAIT) cnt_q <= cnt_q + 1;
   end
   // standby falls only once mute has fallen
   always_ff @(posedge clk_i) sb_q <= !reset_i && (up_i || um_q);
   // unmute after the settle wait, unless told to be early
   always_ff @(posedge clk_i) um_q <= !reset_i && up_i && (cnt_q >= WAIT || early_i);
   // flops reach the pins 1 ns after the edge; the forced-mute request passes straight through
   assign #1 standby_n_o = sb_q;
   assign #1 um_dly = um_q;
   assign mute_n_o = um_dly && !mute_req_i;
endmodule // apss_ctrl_model

// file: test/amp_power_stage_sequencer_tb.sv
// self-checking bench for the power stage sequencer
// assumes shortened hold, settle and ramp counts
`timescale 1ns/1ps
module amp_power_stage_sequencer_tb;
   import apss_pkg::*;
   localparam int H = 50, P = 5, R = 16, W = 80;
   logic       clk_i = 0, reset_i = 1, clk_en_i = 1, up = 0, early = 0, mreq = 0, e;
   logic       standby_n, mute_n, run, br, tw, twoe, fl, floe;
   logic [7:0] ramp;
   apss_mon_t  mon = 5'b00111;
   apss_temp_t temp = 2'b00;
   int         n_mismatch = 0, checks = 0, seed = 32'h72016887, n, d;
   always #5 clk_i = ~clk_i;
   apss_ctrl_model #(.WAIT(W)) ctrl (.clk_i, .reset_i, .up_i(up), .early_i(early),
      .mute_req_i(mreq), .standby_n_o(standby_n), .mute_n_o(mute_n));
   apss_sequencer #(.HOLD_CYCLES(H), .PROP_CYCLES(P), .RAMP_CYCLES(R)) dut (.clk_i, .reset_i,
      .clk_en_i, .standby_n_i(standby_n), .mute_n_i(mute_n), .mon_i(mon), .temp_i(temp),
      .modulator_run_o(run), .bridge_enable_o(br), .ramp_level_o(ramp),
      .thermal_warning_n_o(tw), .thermal_warning_n_oe_n_o(twoe), .fault_n_o(fl),
      .fault_n_oe_n_o(floe));
   function automatic logic is_fault(apss_mon_t m);
      return m.overcurrent | m.overtemp | !m.power_rail_ok | !m.logic_rail_ok | !m.clock_ok;
   endfunction
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   task automatic wait_br(input int lim);
      n = 0;
      while (br !== 1'b1 && n < lim) begin
         wt(1);
         n++;
      end
      chk(n < lim, 1);
      if (n >= lim) summarize();
   endtask
   initial begin
      wt(16);
      reset_i = 0;
      chk({run, br, twoe, floe, tw, fl}, 8'h0C);
      up = 1;
      early = 1;
      wt(3);
      chk({run, br}, 8'h2);
      // a random freeze inside the hold shifts the whole sequence by d cycles
      d = 1 + ($unsigned($random(seed)) % 8);
      clk_en_i = 0;
      wt(d);
      clk_en_i = 1;
      wait_br(200);
      chk(n == H + P, 1);
      chk(ramp != 8'hFF, 1);
      wt(R + 2);
      chk(ramp, 8'hFF);
      mreq = 1;
      wt(3);
      chk(br, 0);
      mreq = 0;
      wait_br(10);
      for (int k = 0; k < 5; k++) begin
         mon = 5'b00111 ^ (5'h01 << k);
         e = !is_fault(mon);
         wt(1);
         mon = 5'b00111;
         wt(1);
         chk({floe, br}, {e, 1'b0});
         wt(2 + ($unsigned($random(seed)) % 8));
         chk(floe, 0);
         mreq = 1;
         wt(3);
         chk(floe, 1);
         mreq = 0;
         wait_br(20);
      end
      temp = 2'b10;
      wt(1);
      temp = 2'b00;
      wt(1);
      chk(twoe, 0);
      wt(3 + ($unsigned($random(seed)) % 16));
      chk(twoe, 0);
      temp = 2'b01;
      wt(3);
      chk(twoe, 1);
      up = 0;
      wt(5);
      chk({run, br}, 0);
      mon = 5'h10 | 5'($random(seed));
      wt(3);
      chk(floe, 1);
      mon = 5'b00111;
      up = 1;
      early = 0;
      wait_br(200);
      chk(n == W + 2, 1);
      summarize();
   end
endmodule // amp_power_stage_sequencer_tb
